// ===== rtl/pll_lock_detect_and_pump_control.v
// Lock detect window, lock flag, pin mux, slip prevention and pump settings
// Summary of operation
// [RULE1] Lock enable gates all lock detection; cleared means no evaluation.
// [RULE2] Select clear gives fixed short window; set gives digitally timed window.
// [RULE3] Digital window: two-bit ring config, two-bit period count sets length.
// [RULE4] Ring test with output select 0111 shows ring on output two; detection halts.
// [RULE5] Ten-bit threshold of consecutive in-window arrivals declares lock.
// [RULE6] Flag sets at threshold, clears at once on an out-of-window arrival.
// [RULE7] Lock flag is read only over the serial port.
// [RULE8] Always-show bit drives the lock flag on the shared pin continuously.
// [RULE9] Auto-mux shows lock except during serial read, then serial data.
// [RULE10] Asymmetric enable with direction set lags window; direction clear leads; code: set delays start by ASYM_CYC; clear lengthens only the fixed window.
// [RULE11] Software sizes window as offset plus eight VCO periods times 1.3.
// [RULE12] Slip prevention keeps detector gain maximal until frequency error near zero.
// [RULE13] Slip prevention shifts divide ratio by four-bit magnitude toward reference.
// [RULE14] Software keeps slip magnitude within 20 percent of target divide.
// [RULE15] Divider never goes below 32, even during correction.
// [RULE16] Up and down pump currents are five-bit codes, 125 uA per step.
// [RULE17] Three-bit trim codes per pump add 14.7 uA per step.
// [RULE18] Four-bit leakage codes per pump add 28.7 uA per step.
// [RULE19] Software limits leakage to 25 percent of pump current.
// [RULE20] Up and down enables mask pumping; both clear tri-states the pump.
// [RULE21] Any out-of-window arrival restarts the consecutive counter from zero.
`timescale 1ns/1ps
`default_nettype none
`include "lock_detect_consts.vh"
module pll_lock_detect_and_pump_control #(
  parameter WINCNT_W = `WINCNT_W,
  parameter ASYM_CYC = 2
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst,
  // Edge inputs from the dividers (asynchronous)
  input  wire                    ref_edge_in,
  input  wire                    vco_edge_in,
  // Lock detect configuration
  input  wire                    lock_detect_en,
  input  wire                    window_digital_sel,
  input  wire [1:0]              ring_cfg,
  input  wire [1:0]              window_duration,
  input  wire                    ring_testmode,
  input  wire [3:0]              gpo_select,
  input  wire [WINCNT_W-1:0]     wincnt_max,
  input  wire                    win_asym_enable,
  input  wire                    win_asym_lag,
  // Shared pin control
  input  wire                    pin_shows_lock_always,
  input  wire                    pin_lock_automux,
  input  wire                    serial_read_active,
  input  wire                    serial_data_out,
  // Slip prevention
  input  wire                    slip_prevention_en,
  input  wire [15:0]             target_divide,
  input  wire [3:0]              slip_correction_magnitude,
  // Pump settings
  input  wire                    up_out_en,
  input  wire                    down_out_en,
  input  wire                    pfd_up,
  input  wire                    pfd_down,
  input  wire [4:0]              pump_up_current,
  input  wire [4:0]              pump_down_current,
  input  wire [2:0]              pump_up_fine_adjust,
  input  wire [2:0]              pump_down_fine_adjust,
  input  wire [3:0]              pump_up_leakage,
  input  wire [3:0]              pump_down_leakage,
  // Status and pins
  output reg                     locked_flag,
  output reg                     lock_or_serial_out_pin,
  output reg                     general_out_two,
  output reg  [15:0]             vco_divide_ratio,
  output reg                     pfd_gain_max,
  output reg                     pump_up_drive,
  output reg                     pump_down_drive,
  output reg                     pump_tristate,
  output reg  [15:0]             pump_up_ua,
  output reg  [15:0]             pump_down_ua
);

////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [1:0] ref_sync_reg;
reg [1:0] vco_sync_reg;
reg       ref_prev_reg;
reg       vco_prev_reg;
always @(posedge clk) begin
  if (rst) begin
    ref_sync_reg <= 2'b00;
    vco_sync_reg <= 2'b00;
    ref_prev_reg <= 1'b0;
    vco_prev_reg <= 1'b0;
  end else begin
    ref_sync_reg <= {ref_sync_reg[0], ref_edge_in};
    vco_sync_reg <= {vco_sync_reg[0], vco_edge_in};
    ref_prev_reg <= ref_sync_reg[1];
    vco_prev_reg <= vco_sync_reg[1];
  end
end
wire ref_rise = ref_sync_reg[1] & ~ref_prev_reg;
wire vco_rise = vco_sync_reg[1] & ~vco_prev_reg;

////////////////////////////////////////////////////////////////////////
// Window generation
wire ring_test = ring_testmode && (gpo_select == `GPO_SEL_RING);
wire evaluate  = lock_detect_en && !ring_test; // [RULE1] [RULE4]

// Lag shifts opening later by delaying the window start past the reference
reg [3:0] delay_reg;
reg       start_reg;
always @(posedge clk) begin
  if (rst) begin
    delay_reg <= 4'h0;
    start_reg <= 1'b0;
  end else begin
    start_reg <= 1'b0;
    if (ref_rise) begin
      if (win_asym_enable && win_asym_lag) // [RULE10]
        delay_reg <= ASYM_CYC[3:0];
      else
        start_reg <= 1'b1;
    end else if (delay_reg != 4'h0) begin
      delay_reg <= delay_reg - 4'h1;
      if (delay_reg == 4'h1)
        start_reg <= 1'b1;
    end
  end
end

reg [7:0] analog_cnt_reg;
wire [15:0] analog_len = `WIN_CYCLES + ((win_asym_enable && !win_asym_lag) ? {8'h00, ASYM_CYC[7:0]} : 16'h0000);
always @(posedge clk) begin
  if (rst)
    analog_cnt_reg <= 8'h00;
  else if (start_reg)
    analog_cnt_reg <= analog_len[7:0]; // [RULE2] [RULE10]
  else if (analog_cnt_reg != 8'h00)
    analog_cnt_reg <= analog_cnt_reg - 8'h01;
end

wire ring_open;
wire ring_clk;
ring_window u_ring (
  .clk         (clk),
  .rst         (rst),
  .ring_cfg    (ring_cfg),
  .duration    (window_duration),
  .start       (start_reg),
  .window_open (ring_open),
  .ring_osc    (ring_clk)
); // [RULE3]

wire window = window_digital_sel ? ring_open : (analog_cnt_reg != 8'h00); // [RULE2]

////////////////////////////////////////////////////////////////////////
// Lock counting
reg [WINCNT_W-1:0] run_reg;
always @(posedge clk) begin
  if (rst) begin
    run_reg     <= {WINCNT_W{1'b0}};
    locked_flag <= 1'b0;
  end else if (!evaluate) begin
    run_reg <= {WINCNT_W{1'b0}}; // [RULE1]
  end else if (vco_rise) begin
    if (window || start_reg) begin
      if (run_reg < wincnt_max)
        run_reg <= run_reg + 1'b1;
      if (run_reg + 1'b1 >= wincnt_max)
        locked_flag <= 1'b1; // [RULE5] [RULE6]
    end else begin
      run_reg     <= {WINCNT_W{1'b0}}; // [RULE21]
      locked_flag <= 1'b0; // [RULE6]
    end
  end
end
// Flag has no write path [RULE7]

////////////////////////////////////////////////////////////////////////
// Shared pin and test output
always @(posedge clk) begin
  if (rst) begin
    lock_or_serial_out_pin <= 1'b0;
    general_out_two        <= 1'b0;
  end else begin
    if (pin_shows_lock_always)
      lock_or_serial_out_pin <= locked_flag; // [RULE8]
    else if (pin_lock_automux)
      lock_or_serial_out_pin <= serial_read_active ? serial_data_out : locked_flag; // [RULE9]
    else
      lock_or_serial_out_pin <= serial_data_out;
    general_out_two <= ring_test ? ring_clk : 1'b0; // [RULE4]
  end
end

////////////////////////////////////////////////////////////////////////
// Slip prevention
reg vco_late_reg;
reg vco_early_reg;
always @(posedge clk) begin
  if (rst) begin
    vco_late_reg  <= 1'b0;
    vco_early_reg <= 1'b0;
  end else begin
    vco_late_reg  <= pfd_up && !locked_flag;
    vco_early_reg <= pfd_down && !locked_flag;
  end
end
wire [15:0] div_w;
wire        gain_w;
slip_divider u_slip (
  .clk       (clk),
  .rst       (rst),
  .enable    (slip_prevention_en),
  .vco_late  (vco_late_reg),
  .vco_early (vco_early_reg),
  .target_n  (target_divide),
  .magnitude (slip_correction_magnitude),
  .divide_n  (div_w),
  .gain_max  (gain_w)
); // [RULE12] [RULE13] [RULE15]

////////////////////////////////////////////////////////////////////////
// Pump gating and current setting in tenths of uA
// Full scale needs sixteen bits in tenths of uA
function [15:0] pump_ua;
  input [4:0] cur;
  input [2:0] trim;
  input [3:0] leak;
  begin
    pump_ua = {11'h000, cur} * `PUMP_CUR_STEP + {13'h0000, trim} * `PUMP_TRIM_STEP
            + {12'h000, leak} * `PUMP_LEAK_STEP;
  end
endfunction

always @(posedge clk) begin
  if (rst) begin
    vco_divide_ratio <= `MIN_DIVIDE;
    pfd_gain_max     <= 1'b0;
    pump_up_drive    <= 1'b0;
    pump_down_drive  <= 1'b0;
    pump_tristate    <= 1'b1;
    pump_up_ua       <= 16'h0000;
    pump_down_ua     <= 16'h0000;
  end else begin
    vco_divide_ratio <= div_w;
    pfd_gain_max     <= gain_w;
    pump_up_drive    <= pfd_up && up_out_en; // [RULE20]
    pump_down_drive  <= pfd_down && down_out_en; // [RULE20]
    pump_tristate    <= !up_out_en && !down_out_en; // [RULE20]
    pump_up_ua       <= pump_ua(pump_up_current, pump_up_fine_adjust, pump_up_leakage); // [RULE16] [RULE17] [RULE18]
    pump_down_ua     <= pump_ua(pump_down_current, pump_down_fine_adjust, pump_down_leakage); // [RULE16] [RULE17] [RULE18]
  end
end

endmodule // pll_lock_detect_and_pump_control
`default_nettype wire

// ===== rtl/lock_detect_consts.vh
// Constants for the lock detect and pump control block
`ifndef LOCK_DETECT_CONSTS_VH
`define LOCK_DETECT_CONSTS_VH
`define ANALOG_WIN_NS       16'h000A
`define CLK_PERIOD_NS       16'h0064
`define WIN_CYCLES          ((`ANALOG_WIN_NS + `CLK_PERIOD_NS - 16'h0001) / `CLK_PERIOD_NS)
`define WINCNT_W            10
`define GPO_SEL_RING        4'h7
`define MIN_DIVIDE          16'h0020
`define RING_BASE_PERIODS   4'h1
`define PUMP_CUR_W          5
`define PUMP_TRIM_W         3
`define PUMP_LEAK_W         4
`define SLIP_MAG_W          4
`define PUMP_CUR_STEP       16'h04E2
`define PUMP_TRIM_STEP      16'h0093
`define PUMP_LEAK_STEP      16'h011F
`endif

// ===== rtl/ring_window.v
// Digital one-shot window timed from a ring oscillator model
`timescale 1ns/1ps
`default_nettype none
`include "lock_detect_consts.vh"
module ring_window (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Configuration
  input  wire [1:0] ring_cfg,
  input  wire [1:0] duration,
  // Trigger and outputs
  input  wire       start,
  output reg        window_open,
  output reg        ring_osc
);
  reg [3:0] div_reg;
  reg [3:0] per_reg;
  wire [3:0] half = {2'b00, ring_cfg} + `RING_BASE_PERIODS;
  always @(posedge clk) begin
    if (rst) begin
      div_reg     <= 4'h0;
      ring_osc    <= 1'b0;
      per_reg     <= 4'h0;
      window_open <= 1'b0;
    end else begin
      if (div_reg >= half - 4'h1) begin
        div_reg  <= 4'h0;
        ring_osc <= ~ring_osc;
        if (window_open && ring_osc) begin
          if (per_reg == {2'b00, duration})
            window_open <= 1'b0;
          else
            per_reg <= per_reg + 4'h1;
        end
      end else begin
        div_reg <= div_reg + 4'h1;
      end
      if (start) begin
        window_open <= 1'b1;
        per_reg     <= 4'h0;
      end
    end
  end
endmodule // ring_window
`default_nettype wire

// ===== rtl/slip_divider.v
// Divide-ratio adjustment during cycle-slip prevention
`timescale 1ns/1ps
`default_nettype none
`include "lock_detect_consts.vh"
module slip_divider (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Control
  input  wire        enable,
  input  wire        vco_late,
  input  wire        vco_early,
  input  wire [15:0] target_n,
  input  wire [3:0]  magnitude,
  // Result
  output reg  [15:0] divide_n,
  output reg         gain_max
);
  function [15:0] floor_clamp;
    input [15:0] v;
    begin
      floor_clamp = (v < `MIN_DIVIDE) ? `MIN_DIVIDE : v;
    end
  endfunction
  wire [15:0] mag16 = {12'h000, magnitude};
  always @(posedge clk) begin
    if (rst) begin
      divide_n <= `MIN_DIVIDE;
      gain_max <= 1'b0;
    end else if (enable && vco_late) begin
      divide_n <= floor_clamp(target_n - ((target_n > mag16) ? mag16 : target_n)); // [RULE13] [RULE15]
      gain_max <= 1'b1; // [RULE12]
    end else if (enable && vco_early) begin
      divide_n <= floor_clamp(target_n + mag16); // [RULE13]
      gain_max <= 1'b1; // [RULE12]
    end else begin
      divide_n <= floor_clamp(target_n); // [RULE15]
      gain_max <= 1'b0;
    end
  end
endmodule // slip_divider
`default_nettype wire

// ===== sim/lock_pump_checker.sv
// Port assertions for the lock detect and pump control block
`timescale 1ns/1ps
`default_nettype none
module lock_pump_checker #(
  parameter WINCNT_W = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Watched ports
  input wire logic        lock_detect_en,
  input wire logic        ring_testmode,
  input wire logic [3:0]  gpo_select,
  input wire logic        pin_shows_lock_always,
  input wire logic        pin_lock_automux,
  input wire logic        serial_read_active,
  input wire logic        up_out_en,
  input wire logic        down_out_en,
  input wire logic        locked_flag,
  input wire logic        lock_or_serial_out_pin,
  input wire logic [15:0] vco_divide_ratio,
  input wire logic        pump_up_drive,
  input wire logic        pump_down_drive,
  input wire logic        pump_tristate
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence s_ring_test;
    (ring_testmode && gpo_select == 4'h7) [*3];
  endsequence
  sequence s_pin_always;
    pin_shows_lock_always [*2] ##0 $stable(locked_flag);
  endsequence
  sequence s_pin_auto;
    (!pin_shows_lock_always && pin_lock_automux && !serial_read_active) [*2] ##0 $stable(locked_flag);
  endsequence
  ////////////////////////////////////////////////////////////
  a_divide_floor: assert property (vco_divide_ratio >= 16'h0020)
    else $error("divide ratio below floor");
  a_pump_tristate: assert property (!up_out_en && !down_out_en |=> pump_tristate)
    else $error("pump not tri-stated");
  a_up_masked: assert property (!up_out_en |=> !pump_up_drive)
    else $error("up pump not masked");
  a_down_masked: assert property (!down_out_en |=> !pump_down_drive)
    else $error("down pump not masked");
  a_pin_always: assert property (s_pin_always |-> lock_or_serial_out_pin == locked_flag)
    else $error("pin not showing lock");
  a_pin_automux: assert property (s_pin_auto |-> lock_or_serial_out_pin == locked_flag)
    else $error("automux pin not showing lock");
  a_lock_needs_en: assert property ($rose(locked_flag) |-> $past(lock_detect_en))
    else $error("lock declared while disabled");
  a_ring_no_lock: assert property (s_ring_test |-> !$rose(locked_flag))
    else $error("lock declared in ring test");
endmodule // lock_pump_checker
bind pll_lock_detect_and_pump_control lock_pump_checker #(.WINCNT_W(WINCNT_W)) lock_chk (
  .clk, .rst, .lock_detect_en, .ring_testmode, .gpo_select, .pin_shows_lock_always,
  .pin_lock_automux, .serial_read_active, .up_out_en, .down_out_en, .locked_flag,
  .lock_or_serial_out_pin, .vco_divide_ratio, .pump_up_drive, .pump_down_drive, .pump_tristate
);
`default_nettype wire

// ===== sim/edge_source.sv
// Reference and divided VCO edge source, 64 cycle period
`timescale 1ns/1ps
`default_nettype none
module edge_source (
  // Clock
  input  wire logic       clk,
  // Control
  input  wire logic       run,
  input  wire logic [5:0] vco_delay,
  // Edges
  output var  logic       ref_edge,
  output var  logic       vco_edge
);
  logic [5:0] phase_reg;
  logic [5:0] vco_phase;
  assign vco_phase = phase_reg - vco_delay;
  always @(posedge clk) begin
    phase_reg <= run ? phase_reg + 6'h01 : 6'h00;
    // Pulses four cycles wide so the synchroniser sees them
    ref_edge <= run && phase_reg < 6'h04;
    vco_edge <= run && vco_phase < 6'h04;
  end
endmodule // edge_source
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the lock detect and pump control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, gpo_seen = 1'b0;
  logic [5:0] dly = 6'h00;
  logic ref_edge_in, vco_edge_in, locked_flag, lock_or_serial_out_pin, general_out_two;
  logic pump_up_drive, pump_down_drive, pump_tristate, pfd_gain_max;
  logic [15:0] pump_up_ua, pump_down_ua;
  logic [15:0] vco_divide_ratio;
  logic lock_detect_en = 1'b1, window_digital_sel = 1'b1, ring_testmode = 1'b0;
  logic win_asym_enable = 1'b0, win_asym_lag = 1'b0, slip_prevention_en = 1'b0;
  logic pin_shows_lock_always = 1'b0, pin_lock_automux = 1'b0;
  logic serial_read_active = 1'b0, serial_data_out = 1'b0;
  logic up_out_en = 1'b1, down_out_en = 1'b1, pfd_up = 1'b0, pfd_down = 1'b0;
  logic [1:0] ring_cfg = 2'h3, window_duration = 2'h3;
  logic [3:0] gpo_select = 4'h0, slip_correction_magnitude = 4'h5;
  logic [9:0] wincnt_max = 10'h003;
  logic [15:0] target_divide = 16'h0064;
  logic [4:0] pump_up_current = 5'h00, pump_down_current = 5'h00;
  logic [2:0] pump_up_fine_adjust = 3'h0, pump_down_fine_adjust = 3'h0;
  logic [3:0] pump_up_leakage = 4'h0, pump_down_leakage = 4'h0;
  int fails = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (general_out_two === 1'b1) gpo_seen <= 1'b1;
  edge_source peer (.clk, .run, .vco_delay(dly), .ref_edge(ref_edge_in), .vco_edge(vco_edge_in));
  pll_lock_detect_and_pump_control uut (.clk, .rst, .ref_edge_in, .vco_edge_in, .lock_detect_en,
    .window_digital_sel, .ring_cfg, .window_duration, .ring_testmode, .gpo_select, .wincnt_max,
    .win_asym_enable, .win_asym_lag, .pin_shows_lock_always, .pin_lock_automux, .serial_read_active,
    .serial_data_out, .slip_prevention_en, .target_divide, .slip_correction_magnitude, .up_out_en,
    .down_out_en, .pfd_up, .pfd_down, .pump_up_current, .pump_down_current, .pump_up_fine_adjust,
    .pump_down_fine_adjust, .pump_up_leakage, .pump_down_leakage, .locked_flag, .lock_or_serial_out_pin,
    .general_out_two, .vco_divide_ratio, .pfd_gain_max, .pump_up_drive, .pump_down_drive,
    .pump_tristate, .pump_up_ua, .pump_down_ua);
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic burst(input int n, input logic [5:0] d, input logic exp);
    @(posedge clk);
    dly <= d;
    run <= 1'b1;
    cyc(n * 64);
    run <= 1'b0;
    cyc(10);
    @(negedge clk);
    chk(locked_flag, exp);
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_slip();
    @(posedge clk);
    slip_prevention_en <= 1'b1;
    pfd_up <= 1'b1;
    cyc(4);
    @(negedge clk);
    chk(vco_divide_ratio, 16'h005F);
    chk(pfd_gain_max, 1'b1);
    @(posedge clk);
    pfd_up <= 1'b0;
    pfd_down <= 1'b1;
    cyc(4);
    @(negedge clk);
    chk(vco_divide_ratio, 16'h0069);
    @(posedge clk);
    target_divide <= 16'h0024;
    slip_correction_magnitude <= 4'h7;
    pfd_down <= 1'b0;
    pfd_up <= 1'b1;
    cyc(4);
    @(negedge clk);
    chk(vco_divide_ratio, 16'h0020);
    @(posedge clk);
    pfd_up <= 1'b0;
    slip_prevention_en <= 1'b0;
  endtask
  task automatic t_lock();
    burst(2, 6'h02, 1'b0);
    burst(1, 6'h02, 1'b1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {pin_shows_lock_always, pin_lock_automux, serial_read_active} <= i[2:0];
      cyc(3);
      @(negedge clk);
      chk(lock_or_serial_out_pin, i[2] | (i[1] & !i[0]));
    end
    burst(1, 6'h28, 1'b0);
    burst(2, 6'h02, 1'b0);
    burst(1, 6'h02, 1'b1);
  endtask
  task automatic t_window();
    burst(1, 6'h28, 1'b0);
    window_duration <= 2'h0;
    burst(3, 6'h14, 1'b0);
    window_duration <= 2'h3;
    window_digital_sel <= 1'b0;
    burst(3, 6'h06, 1'b0);
    window_digital_sel <= 1'b1;
  endtask
  task automatic t_gate();
    @(posedge clk);
    lock_detect_en <= 1'b0;
    burst(3, 6'h02, 1'b0);
    lock_detect_en <= 1'b1;
    ring_testmode <= 1'b1;
    gpo_select <= 4'h7;
    burst(3, 6'h02, 1'b0);
    chk(gpo_seen, 1'b1);
    ring_testmode <= 1'b0;
    gpo_select <= 4'h0;
    burst(3, 6'h02, 1'b1);
  endtask
  task automatic t_pump();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {up_out_en, down_out_en, pfd_up, pfd_down} <= i[3:0];
      pump_up_current <= {1'b0, i[3:0]};
      pump_down_current <= {1'b0, i[3:0]};
      pump_up_fine_adjust <= i[2:0];
      pump_down_fine_adjust <= i[2:0];
      pump_up_leakage <= i[3:0];
      pump_down_leakage <= i[3:0];
      cyc(2);
      @(negedge clk);
      chk({pump_up_drive, pump_down_drive, pump_tristate}, {i[3] & i[1], i[2] & i[0], !i[3] & !i[2]});
      chk(pump_up_ua, 16'(i * 1250 + (i % 8) * 147 + i * 287));
      chk(pump_down_ua, 16'(i * 1250 + (i % 8) * 147 + i * 287));
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst <= 1'b0;
    t_slip();
    t_lock();
    t_window();
    t_gate();
    t_pump();
    summarize();
  end
  initial begin
    #1_000_000;
    fails++;
    summarize();
  end
endmodule // tb
`default_nettype wire
